/* rtl/lrc_regs.svh */
// Register indices, field positions, reset values and timing constants
`ifndef LRC_REGS_SVH
`define LRC_REGS_SVH

// Printed register indices; byte address is four times the index
`define LRC_IDX_L1_ACT     8'h50
`define LRC_IDX_L1_LPM     8'h51
`define LRC_IDX_L1_HIB     8'h52
`define LRC_IDX_L1_HPM     8'h53
`define LRC_IDX_L1_SEQ     8'h54
`define LRC_IDX_L1_CFG     8'h55
`define LRC_IDX_L2_ACT     8'h60
`define LRC_IDX_L2_LPM     8'h61
`define LRC_IDX_L2_HIB     8'h62
`define LRC_IDX_L2_HPM     8'h63
`define LRC_IDX_L2_SEQ     8'h64
`define LRC_IDX_L2_CFG     8'h65
`define LRC_IDX_IRQ_STS    8'h70
`define LRC_IDX_IRQ_MSK    8'h71

// Slot numbers inside one regulator's bank
`define LRC_SLOT_SEQ       3'h4
`define LRC_SLOT_CFG       3'h5
`define LRC_NUM_SLOTS      6

// Power-on values
`define LRC_RST_L1_ACT     8'h80
`define LRC_RST_L1_LPM     8'h80
`define LRC_RST_L1_HIB     8'h00
`define LRC_RST_L1_HPM     8'h80
`define LRC_RST_L1_SEQ     8'h09
`define LRC_RST_L1_CFG     8'hb0
`define LRC_RST_L2_MODE    8'h37
`define LRC_RST_L2_SEQ     8'h01
`define LRC_RST_L2_CFG     8'ha0
`define LRC_RST_IRQ_MSK    2'h0

// Reserved bits forced on the stored value
`define LRC_MODE_KEEP_MASK 8'hbf
`define LRC_CFG_KEEP_MASK  8'hbf
`define LRC_L1_CFG_FORCE   8'h10

// Sequencing delay unit
`define LRC_CLK_MHZ        25
`define LRC_DELAY_UNIT_US  1000

`endif

/* rtl/lrc_pkg.sv */
// Types shared by the linear regulator control register block
package lrc_pkg;

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_LOWPOWER,
    MODE_HIBERNATE,
    MODE_HIPERF
  } lrc_opmode_type;

  typedef struct packed {
    logic       enable;
    logic       reserved;
    logic [5:0] voltage_code;
  } lrc_mode_type;

  typedef struct packed {
    logic [1:0] soft_start_rate;
    logic [1:0] sequence_step;
    logic       sequence_enable;
    logic [2:0] delay;
  } lrc_seq_type;

  typedef struct packed {
    logic       fault_mask;
    logic       reserved6;
    logic       discharge_control;
    logic       reserved4;
    logic [1:0] scaling_rate;
    logic       reg_enable;
    logic       reg_control_select;
  } lrc_cfg_type;

  // Per-regulator status from the analog side
  typedef struct packed {
    logic fault_flag;
    logic soft_start_done;
    logic power_good;
  } lrc_stat_type;

  // Per-regulator control towards the analog side
  typedef struct packed {
    logic       enable;
    logic [5:0] voltage_code;
    logic [1:0] soft_start_rate;
    logic [1:0] scaling_rate;
    logic       discharge;
    logic       soft_start_go;
  } lrc_ctrl_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT,
    SEQ_UP
  } lrc_seq_state_type;

endpackage : lrc_pkg

/* rtl/lrc_top.sv */
// Linear regulator control registers with APB access and start-up timing
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "lrc_regs.svh"

module lrc_top
  import lrc_pkg::*;
#(
  parameter int NUM_REGS       = 2,
  parameter int DELAY_UNIT_CYC = `LRC_DELAY_UNIT_US * `LRC_CLK_MHZ
) (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [5:0]           voltage_code_strap,
  input  wire lrc_opmode_type       op_mode,
  input  wire logic                 step_go,
  input  wire logic [1:0]           step_now,
  input  wire lrc_stat_type [NUM_REGS-1:0] reg_stat,
  output lrc_ctrl_type [NUM_REGS-1:0]      reg_ctrl,
  output logic                      step_complete,
  output logic                      interrupt_out_n
);

  // Register decode: hit, regulator number, slot (or irq register)
  // Index comes from paddr[11:2]; the two low address bits are ignored
  typedef struct packed {
    logic       hit;
    logic       irq;
    logic       bank;
    logic [2:0] slot;
  } lrc_dec_type;

  function automatic lrc_dec_type decode(input logic [9:0] idx);
    lrc_dec_type d;
    d = '0;
    d.hit = 1'b1;
    unique case (idx)
      {2'h0, `LRC_IDX_L1_ACT}:  d.slot = 3'(MODE_ACTIVE);
      {2'h0, `LRC_IDX_L1_LPM}:  d.slot = 3'(MODE_LOWPOWER);
      {2'h0, `LRC_IDX_L1_HIB}:  d.slot = 3'(MODE_HIBERNATE);
      {2'h0, `LRC_IDX_L1_HPM}:  d.slot = 3'(MODE_HIPERF);
      {2'h0, `LRC_IDX_L1_SEQ}:  d.slot = `LRC_SLOT_SEQ;
      {2'h0, `LRC_IDX_L1_CFG}:  d.slot = `LRC_SLOT_CFG;
      {2'h0, `LRC_IDX_L2_ACT}:  d = '{1'b1, 1'b0, 1'b1, 3'(MODE_ACTIVE)};
      {2'h0, `LRC_IDX_L2_LPM}:  d = '{1'b1, 1'b0, 1'b1, 3'(MODE_LOWPOWER)};
      {2'h0, `LRC_IDX_L2_HIB}:  d = '{1'b1, 1'b0, 1'b1, 3'(MODE_HIBERNATE)};
      {2'h0, `LRC_IDX_L2_HPM}:  d = '{1'b1, 1'b0, 1'b1, 3'(MODE_HIPERF)};
      {2'h0, `LRC_IDX_L2_SEQ}:  d = '{1'b1, 1'b0, 1'b1, `LRC_SLOT_SEQ};
      {2'h0, `LRC_IDX_L2_CFG}:  d = '{1'b1, 1'b0, 1'b1, `LRC_SLOT_CFG};
      {2'h0, `LRC_IDX_IRQ_STS}: d = '{1'b1, 1'b1, 1'b0, 3'h0};
      {2'h0, `LRC_IDX_IRQ_MSK}: d = '{1'b1, 1'b1, 1'b0, 3'h1};
      default:                  d.hit = 1'b0;
    endcase
    return d;
  endfunction : decode

  // Power-on value of one slot
  // Regulator two's four mode slots share one default
  function automatic logic [7:0] reset_value(input int r, input int s);
    logic [7:0] v;
    v = 8'h00;
    if (r == 0) begin
      unique case (s)
        0:       v = `LRC_RST_L1_ACT;
        1:       v = `LRC_RST_L1_LPM;
        2:       v = `LRC_RST_L1_HIB;
        3:       v = `LRC_RST_L1_HPM;
        4:       v = `LRC_RST_L1_SEQ;
        default: v = `LRC_RST_L1_CFG;
      endcase
    end else begin
      unique case (s)
        4:       v = `LRC_RST_L2_SEQ;
        5:       v = `LRC_RST_L2_CFG;
        default: v = `LRC_RST_L2_MODE;
      endcase
    end
    return v;
  endfunction : reset_value

  // Register storage, fault status and mask, bus answer
  logic [7:0]          bank_reg  [NUM_REGS][`LRC_NUM_SLOTS];
  logic [7:0]          bank_next [NUM_REGS][`LRC_NUM_SLOTS];
  logic                strap_done_reg;
  logic                strap_done_next;
  logic [NUM_REGS-1:0] irq_sts_reg;
  logic [NUM_REGS-1:0] irq_sts_next;
  logic [NUM_REGS-1:0] irq_msk_reg;
  logic [NUM_REGS-1:0] irq_msk_next;
  logic [31:0]         prdata_next;
  logic                pready_next;
  logic                pslverr_next;
  lrc_dec_type         dec;
  logic                wr_fire;

  // Current bus address decode
  assign dec     = decode(paddr[11:2]);
  // Write commits only at the access edge with pready high
  assign wr_fire = psel & penable & pready & pwrite;

  // Register bank next values
  always_comb begin
    bank_next       = bank_reg;
    strap_done_next = 1'b1;
    irq_msk_next    = irq_msk_reg;
    // Later changes on the strap pin are ignored
    // strap code caught once after reset release
    if (!strap_done_reg) begin
      for (int s = 0; s < 4; s++) begin
        bank_next[0][s][5:0] = voltage_code_strap;
      end
    end
    if (wr_fire && dec.hit && !dec.irq && int'(dec.bank) < NUM_REGS) begin
      bank_next[dec.bank][dec.slot] = pwdata[7:0];
      if (dec.slot < `LRC_SLOT_SEQ) begin
        bank_next[dec.bank][dec.slot] = pwdata[7:0] & `LRC_MODE_KEEP_MASK;
      end else if (dec.slot == `LRC_SLOT_CFG) begin
        bank_next[dec.bank][dec.slot] = pwdata[7:0] & `LRC_CFG_KEEP_MASK;
        if (dec.bank == 1'b0) begin
          bank_next[0][`LRC_SLOT_CFG] = bank_next[0][`LRC_SLOT_CFG] |
                                        `LRC_L1_CFG_FORCE;
        end
      end
    end
    // Mask register write
    if (wr_fire && dec.hit && dec.irq && dec.slot == 3'h1) begin
      irq_msk_next = pwdata[NUM_REGS-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        for (int s = 0; s < `LRC_NUM_SLOTS; s++) begin
          bank_reg[r][s] <= reset_value(r, s);
        end
      end
      strap_done_reg <= 1'b0;
      irq_msk_reg    <= `LRC_RST_IRQ_MSK;
    end else begin
      bank_reg       <= bank_next;
      strap_done_reg <= strap_done_next;
      irq_msk_reg    <= irq_msk_next;
    end
  end

  // APB answer: data latched in setup, one access cycle
  // Decoding in setup lets the answer stand through the access cycle
  always_comb begin
    prdata_next  = prdata;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pready_next  = 1'b1;
      pslverr_next = !dec.hit || (!dec.irq && int'(dec.bank) >= NUM_REGS);
      prdata_next  = 32'h0000_0000;
      if (dec.hit && dec.irq) begin
        prdata_next[NUM_REGS-1:0] = (dec.slot == 3'h0) ? irq_sts_reg
                                                       : irq_msk_reg;
      end else if (dec.hit && int'(dec.bank) < NUM_REGS) begin
        prdata_next[7:0] = bank_reg[dec.bank][dec.slot];
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_next;
      pready  <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // Delay unit tick divider
  localparam int TW = $clog2(DELAY_UNIT_CYC + 1);
  logic [TW-1:0] tick_cnt_reg;
  logic [TW-1:0] tick_cnt_next;
  logic          tick;

  assign tick = (tick_cnt_reg == TW'(DELAY_UNIT_CYC - 1));

  // Free-running count; units are not aligned to step starts
  always_comb begin
    tick_cnt_next = tick ? '0 : tick_cnt_reg + TW'(1);
  end

  // Divider counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // Per-regulator sequencing and output control
  logic [NUM_REGS-1:0] step_ok;
  logic [NUM_REGS-1:0] irq_src;
  lrc_ctrl_type [NUM_REGS-1:0] ctrl_next;

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      lrc_mode_type      mode_sel;
      lrc_seq_type       seq;
      lrc_cfg_type       cfg;
      lrc_cfg_type       cfg_next;
      lrc_seq_state_type st_reg;
      lrc_seq_state_type st_next;
      logic [2:0]        dly_reg;
      logic [2:0]        dly_next;
      logic              go_pulse;
      logic              auto_en;
      logic              en;

      assign mode_sel = lrc_mode_type'(bank_reg[g][int'(op_mode)]);
      assign seq      = lrc_seq_type'(bank_reg[g][`LRC_SLOT_SEQ]);
      assign cfg      = lrc_cfg_type'(bank_reg[g][`LRC_SLOT_CFG]);
      // Look-ahead copy so the interrupt pin follows a mask write at once
      assign cfg_next = lrc_cfg_type'(bank_next[g][`LRC_SLOT_CFG]);

      // Start-up wait and soft-start launch
      always_comb begin
        st_next  = st_reg;
        dly_next = dly_reg;
        go_pulse = 1'b0;
        unique case (st_reg)
          SEQ_IDLE: begin
            // step match; gated by sequence enable
            if (step_go && step_now == seq.sequence_step &&
                seq.sequence_enable) begin
              st_next  = SEQ_WAIT;
              dly_next = seq.delay;
            end
          end
          SEQ_WAIT: begin
            if (tick) begin
              if (dly_reg == 3'h0) begin
                st_next  = SEQ_UP;
                go_pulse = 1'b1;
              end else begin
                dly_next = dly_reg - 3'h1;
              end
            end
          end
          // No power-down sequence; only reset leaves this state
          SEQ_UP:  st_next = SEQ_UP;
          // Spare state code recovers to idle
          default: st_next = SEQ_IDLE;
        endcase
      end

      // Sequencer state registers
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          st_reg  <= SEQ_IDLE;
          dly_reg <= 3'h0;
        end else begin
          st_reg  <= st_next;
          dly_reg <= dly_next;
        end
      end

      assign auto_en = mode_sel.enable && (st_reg == SEQ_UP);
      assign en = cfg.reg_control_select ? cfg.reg_enable : auto_en;

      // A regulator of another step never holds the step back
      // flags neglected when sequence disabled
      assign step_ok[g] = (seq.sequence_step != step_now) ||
                          !seq.sequence_enable ||
                          (reg_stat[g].soft_start_done &&
                           reg_stat[g].power_good);
      assign irq_src[g] = !cfg_next.fault_mask;

      // Control word towards the analog side
      always_comb begin
        ctrl_next[g].enable          = en;
        ctrl_next[g].voltage_code    = mode_sel.voltage_code;
        ctrl_next[g].soft_start_rate = seq.soft_start_rate;
        ctrl_next[g].scaling_rate    = cfg.scaling_rate;
        ctrl_next[g].discharge       = cfg.discharge_control && !en;
        ctrl_next[g].soft_start_go   = go_pulse;
      end
    end
  endgenerate

  // Fault status: set wins over write-one-to-clear
  // A fault in the clearing cycle keeps its bit set, so none is lost
  always_comb begin
    irq_sts_next = irq_sts_reg;
    if (wr_fire && dec.hit && dec.irq && dec.slot == 3'h0) begin
      irq_sts_next = irq_sts_reg & ~pwdata[NUM_REGS-1:0];
    end
    for (int r = 0; r < NUM_REGS; r++) begin
      if (reg_stat[r].fault_flag) begin
        irq_sts_next[r] = 1'b1;
      end
    end
  end

  // Fault status registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_sts_reg <= '0;
    end else begin
      irq_sts_reg <= irq_sts_next;
    end
  end

  logic                step_complete_next;
  logic                interrupt_out_n_next;

  // Interrupt looks ahead at status, mask and fault mask: changes on the same edge as the status bit
  always_comb begin
    step_complete_next   = &step_ok;
    interrupt_out_n_next = ~|(irq_sts_next & irq_msk_next & irq_src);
  end

  // Outputs registered
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_ctrl        <= '0;
      step_complete   <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      reg_ctrl        <= ctrl_next;
      step_complete   <= step_complete_next;
      interrupt_out_n <= interrupt_out_n_next;
    end
  end

endmodule : lrc_top

/* testbench/lrc_top_checker.sv */
// Port assertions for the linear regulator control register block
`timescale 1ns/10ps
module lrc_top_checker
  import lrc_pkg::*;
#(
  parameter int NUM_REGS       = 2,
  parameter int DELAY_UNIT_CYC = 25000
) (
  input wire logic                        mclk,
  input wire logic                        rstn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        step_go,
  input wire lrc_stat_type [NUM_REGS-1:0] reg_stat,
  input wire lrc_ctrl_type [NUM_REGS-1:0] reg_ctrl,
  input wire logic                        interrupt_out_n
);
  int   since_go_reg;
  int   since_go_next;
  logic any_fault;

  // Cycles since the last step start; saturates so it never wraps
  always_comb begin
    since_go_next = since_go_reg;
    if (step_go) since_go_next = 0;
    else if (since_go_reg < 1000000) since_go_next = since_go_reg + 1;
    any_fault = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) any_fault |= reg_stat[i].fault_flag;
  end

  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) since_go_reg <= 1000000;
    else since_go_reg <= since_go_next;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Bus handshake: exactly one access cycle per setup
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_ready: assert property (pslverr |-> pready && psel)
    else $error("error outside access");
  // Refused reads give zero, registers sit in the low byte
  a_err_rdzero: assert property (
    pslverr && !pwrite |-> prdata == 32'h0) else $error("refused data");
  a_rdata_upper: assert property (
    pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  // Pin falls only after a fault or a bus write
  a_irq_cause: assert property (
    $fell(interrupt_out_n) |-> $past(any_fault) || $past(psel && pwrite))
    else $error("interrupt without cause");
  a_ssgo_pulse: assert property (
    reg_ctrl[NUM_REGS-1].soft_start_go |=>
    !reg_ctrl[NUM_REGS-1].soft_start_go) else $error("long start pulse");
  a_ssgo_delay: assert property (
    reg_ctrl[NUM_REGS-1].soft_start_go |->
    since_go_reg <= 8 * DELAY_UNIT_CYC + 2) else $error("late start");
  a_dis_off: assert property (
    reg_ctrl[0].discharge |-> !reg_ctrl[0].enable)
    else $error("discharge while on");

  c_refused: cover property (pslverr);
  c_start: cover property (reg_ctrl[NUM_REGS-1].soft_start_go);
  c_irq: cover property ($fell(interrupt_out_n));
endmodule : lrc_top_checker

/* testbench/lrc_top_tb_top.sv */
// Self-checking bench for the linear regulator control register block
`timescale 1ns/10ps
`include "lrc_regs.svh"

module lrc_top_tb_top;
  import lrc_pkg::*;
  logic               mclk, rstn, psel, penable, pwrite, step_go;
  logic               pready, pslverr, step_complete, interrupt_out_n;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rnd;
  logic [5:0]         strap;
  logic [1:0]         step_now;
  logic [7:0]         idx, wd;
  logic               hit;
  lrc_opmode_type     op_mode;
  lrc_stat_type [1:0] reg_stat;
  lrc_ctrl_type [1:0] reg_ctrl;
  logic [32:0]        exp_q[$];
  int                 miscompares, samples_checked, cyc, n;

  // Delay unit shortened to four cycles
  lrc_top #(.DELAY_UNIT_CYC(4)) dut (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .voltage_code_strap(strap),
    .op_mode(op_mode), .step_go(step_go), .step_now(step_now),
    .reg_stat(reg_stat), .reg_ctrl(reg_ctrl),
    .step_complete(step_complete), .interrupt_out_n(interrupt_out_n));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [32:0] got, input logic [32:0] ex);
    samples_checked++;
    if (got !== ex) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, ex);
    end
  endtask : cmp

  // One transfer; an idle edge follows so psel never toggles twice
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [7:0] d, input logic [32:0] ex);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, a, 2'h0};
    pwdata  <= {24'h0, d};
    if (!w) exp_q.push_back(ex);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    apb(a, 1'b0, 8'h0, {e[8], 24'h0, e[7:0]});
  endtask : rd

  task automatic go(input logic [1:0] s);
    step_now <= s;
    step_go  <= 1'b1;
    @(posedge mclk);
    step_go  <= 1'b0;
  endtask : go

  task automatic pulse_fault();
    reg_stat[0].fault_flag <= 1'b1;
    @(posedge mclk);
    reg_stat[0].fault_flag <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : pulse_fault

  // Write regulator two config, then look at enable, discharge, rate
  task automatic ovr(input logic [7:0] c, input logic [3:0] e);
    wr(`LRC_IDX_L2_CFG, c);
    repeat (2) @(posedge mclk);
    cmp({29'h0, reg_ctrl[1].enable, reg_ctrl[1].discharge,
         reg_ctrl[1].scaling_rate}, {29'h0, e});
  endtask : ovr

  // Read monitor takes the oldest note on every read answer
  always @(posedge mclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp({pslverr, prdata}, exp_q.pop_front());

  // Ceiling well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    rnd = $urandom(27);
    {psel, penable, pwrite, step_go, hit} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    strap = rnd[5:0];
    step_now = 2'h0;
    op_mode = MODE_ACTIVE;
    reg_stat = '0;
    rstn = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      rd(8'h50 + i[7:0], {1'b0, (i != 2), 1'b0, strap});
      rd(8'h60 + i[7:0], {1'b0, `LRC_RST_L2_MODE});
    end
    rd(`LRC_IDX_L1_SEQ, {1'b0, `LRC_RST_L1_SEQ});
    rd(`LRC_IDX_L1_CFG, {1'b0, `LRC_RST_L1_CFG});
    rd(`LRC_IDX_L2_SEQ, {1'b0, `LRC_RST_L2_SEQ});
    rd(`LRC_IDX_L2_CFG, {1'b0, `LRC_RST_L2_CFG});
    rd(`LRC_IDX_IRQ_MSK, 9'h0);
    rd(8'h3f, 9'h100);
    for (int i = 0; i < 12; i++) begin
      idx = (i < 6) ? 8'h50 + i[7:0] : 8'h5a + i[7:0];
      rnd = $urandom();
      wd = rnd[7:0];
      if (i % 6 != 4) wd[6] = 1'b0;
      if (i == 5) wd[4] = 1'b1;
      wr(idx, wd);
      rd(idx, {1'b0, wd});
    end
    wr(`LRC_IDX_IRQ_MSK, 8'h03);
    wr(`LRC_IDX_L1_CFG, 8'h10);
    pulse_fault();
    cmp({32'h0, interrupt_out_n}, 33'h0);
    rd(`LRC_IDX_IRQ_STS, 9'h001);
    wr(`LRC_IDX_IRQ_STS, 8'h01);
    repeat (2) @(posedge mclk);
    cmp({32'h0, interrupt_out_n}, 33'h1);
    wr(`LRC_IDX_L1_CFG, 8'h90);
    pulse_fault();
    cmp({32'h0, interrupt_out_n}, 33'h1);
    wr(`LRC_IDX_IRQ_STS, 8'h01);
    // step one with two units of delay
    wr(`LRC_IDX_L1_SEQ, 8'h20);
    wr(`LRC_IDX_L2_CFG, 8'h00);
    wr(`LRC_IDX_L2_HIB, 8'h05);
    wr(`LRC_IDX_L2_ACT, 8'h95);
    wr(`LRC_IDX_L2_SEQ, 8'h5a);
    go(2'h1);
    n = 0;
    while (reg_ctrl[1].soft_start_go !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    cmp({32'h0, n >= 10 && n <= 13}, 33'h1);
    repeat (2) @(posedge mclk);
    cmp({24'h0, reg_ctrl[1].enable, reg_ctrl[1].voltage_code,
         reg_ctrl[1].soft_start_rate}, 33'h155);
    go(2'h2);
    repeat (40) begin
      @(posedge mclk);
      if (reg_ctrl[0].soft_start_go === 1'b1) hit = 1'b1;
    end
    cmp({30'h0, hit, reg_ctrl[0].enable, step_complete}, 33'h1);
    op_mode <= MODE_HIBERNATE;
    repeat (3) @(posedge mclk);
    cmp({26'h0, reg_ctrl[1].enable, reg_ctrl[1].voltage_code}, 33'h05);
    op_mode <= MODE_ACTIVE;
    ovr(8'h21, 4'h4);
    ovr(8'h00, 4'h8);
    ovr(8'h0f, 4'hb);
    ovr(8'h2c, 4'hb);
    end_sim();
  end
endmodule : lrc_top_tb_top

bind lrc_top lrc_top_checker #(
  .NUM_REGS(NUM_REGS), .DELAY_UNIT_CYC(DELAY_UNIT_CYC)) chk (
  .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .step_go(step_go), .reg_stat(reg_stat), .reg_ctrl(reg_ctrl),
  .interrupt_out_n(interrupt_out_n));
